// ===== rtl/dtc_consts.svh
/*
 * Register offsets, bit positions, reset values and timing counts for the
 * dual timer/counter. Assumes inclusion by bare name from rtl/.
 */
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_OFF_CTRL 8'h88
`define DTC_OFF_MODE 8'h89
`define DTC_OFF_T0_LO 8'h8A
`define DTC_OFF_T1_LO 8'h8B
`define DTC_OFF_T0_HI 8'h8C
`define DTC_OFF_T1_HI 8'h8D
`define DTC_OFF_ACK 8'h90
`define DTC_BYTE_RESET 8'h00
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CTRL_IE1 3
`define DTC_CTRL_IT1 2
`define DTC_CTRL_IE0 1
`define DTC_CTRL_IT0 0
`define DTC_MODE_GATE1 7
`define DTC_MODE_CT1 6
`define DTC_MODE_M1_HI 5
`define DTC_MODE_M1_LO 4
`define DTC_MODE_GATE0 3
`define DTC_MODE_CT0 2
`define DTC_MODE_M0_HI 1
`define DTC_MODE_M0_LO 0
`define DTC_SAMPLE_PERIOD 4'hC
`define DTC_SAMPLE_LAST 4'hB
`define DTC_LOW5_MASK 8'h1F
`define DTC_LOW5_TOP 8'h1F
`define DTC_BYTE_TOP 8'hFF
`define DTC_ZERO8 8'h00
`define DTC_ONE8 8'h01

`endif

// ===== rtl/dtc_pkg.sv
/*
 * Types shared by the dual timer/counter files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_SHORT = 2'b00,
        DTC_MODE_FULL = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic last;
        logic fall;
        logic [3:0] div;
    } dtc_sampler_state_t;
endpackage

// ===== rtl/dtc_count_if.sv
/*
 * Carrier between the count-input sampler and the timer core.
 * Assumes one clock domain, sys_clk.
 */
`timescale 1ns/1ps
interface dtc_count_if;
    logic pin_sync;
    logic fall;
    modport sampler (output pin_sync, output fall);
    modport core (input pin_sync, input fall);
endinterface

// ===== rtl/dtc_sampler.sv
/*
 * Synchronises one external count pin and samples it once per twelve clocks,
 * pulsing fall when a sample goes from one to zero.
 * Assumes a free-running sys_clk and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_sampler
    import dtc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic pin,
    dtc_count_if.sampler cnt
);
    dtc_sampler_state_t st;
    dtc_sampler_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.fall = (st.div == `DTC_SAMPLE_LAST)
            && st.last && !st.s2;
        if (st.div == `DTC_SAMPLE_LAST) begin
            next_st.div = 4'h0;
            next_st.last = st.s2;
        end else begin
            next_st.div = st.div + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st <= '{s1: 1'b1, s2: 1'b1, last: 1'b1, fall: 1'b0, div: 4'h0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign cnt.pin_sync = st.s2;
    assign cnt.fall = st.fall && clk_en;
endmodule

// ===== rtl/dtc_top.sv
/*
 * Dual 16-bit timer/counter with external interrupt flags, reached over
 * Avalon-MM. Holds the control, mode and four byte registers.
 * Assumes a CPU interrupt controller pulses the service-done inputs when a
 * routine has run, and that the pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_top
    import dtc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic count_input_zero,
    input wire logic count_input_one,
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    input wire logic timer_zero_serviced,
    input wire logic timer_one_serviced,
    input wire logic ext_irq_zero_serviced,
    input wire logic ext_irq_one_serviced,
    output logic timer_zero_irq,
    output logic timer_one_irq,
    output logic ext_irq_zero_irq,
    output logic ext_irq_one_irq
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] t0_lo;
        logic [7:0] t0_hi;
        logic [7:0] t1_lo;
        logic [7:0] t1_hi;
        logic ext_irq_zero_pin_s1;
        logic ext_irq_zero_pin_s2;
        logic ext_irq_zero_pin_prev;
        logic ext_irq_one_pin_s1;
        logic ext_irq_one_pin_s2;
        logic ext_irq_one_pin_prev;
        logic ack;
        logic [31:0] rdata;
    } dtc_top_state_t;

    dtc_top_state_t st;
    dtc_top_state_t next_st;

    dtc_count_if cnt0 ();
    dtc_count_if cnt1 ();

    dtc_sampler u_samp0 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin(count_input_zero),
        .cnt(cnt0.sampler)
    );

    dtc_sampler u_samp1 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin(count_input_one),
        .cnt(cnt1.sampler)
    );

    ////////////////////////////////////////////////////////////////////////

    logic wr_hit;
    logic rd_hit;
    logic wr_lane;
    logic [7:0] wbyte;
    dtc_mode_t mode0;
    dtc_mode_t mode1;
    logic en0;
    logic en1;
    logic en_split_hi;
    logic step0;
    logic step1;
    logic of0;
    logic of1;
    logic of_split_hi;
    logic [7:0] rd_byte;

    assign wr_hit = avs_write && !st.ack;
    assign rd_hit = avs_read && !st.ack;
    assign wr_lane = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign mode0 = dtc_mode_t'(st.mode[`DTC_MODE_M0_HI:`DTC_MODE_M0_LO]);
    assign mode1 = dtc_mode_t'(st.mode[`DTC_MODE_M1_HI:`DTC_MODE_M1_LO]);

    // Run gated by the synchronised interrupt pin when gate is set.
    assign en0 = st.ctrl[`DTC_CTRL_TR0]
        && (!st.mode[`DTC_MODE_GATE0] || st.ext_irq_zero_pin_s2);
    assign en1 = st.ctrl[`DTC_CTRL_TR1]
        && (!st.mode[`DTC_MODE_GATE1] || st.ext_irq_one_pin_s2)
        && (mode0 != DTC_MODE_SPLIT);
    assign en_split_hi = st.ctrl[`DTC_CTRL_TR1]
        && (mode0 == DTC_MODE_SPLIT);

    // Counter select picks pin falls, else every clock.
    assign step0 = en0
        && (st.mode[`DTC_MODE_CT0] ? cnt0.fall : 1'b1);
    assign step1 = en1
        && (st.mode[`DTC_MODE_CT1] ? cnt1.fall : 1'b1);

    always_comb begin
        of0 = 1'b0;
        unique case (mode0)
            DTC_MODE_SHORT: of0 = step0 && (st.t0_hi == `DTC_BYTE_TOP)
                && ((st.t0_lo & `DTC_LOW5_MASK) == `DTC_LOW5_TOP);
            DTC_MODE_FULL: of0 = step0 && (st.t0_hi == `DTC_BYTE_TOP)
                && (st.t0_lo == `DTC_BYTE_TOP);
            DTC_MODE_RELOAD: of0 = step0
                && (st.t0_lo == `DTC_BYTE_TOP);
            DTC_MODE_SPLIT: of0 = step0
                && (st.t0_lo == `DTC_BYTE_TOP);
        endcase
    end

    // In split mode the high byte is a pure timer under timer 1's run bit.
    assign of_split_hi = en_split_hi && (st.t0_hi == `DTC_BYTE_TOP);

    always_comb begin
        of1 = 1'b0;
        unique case (mode1)
            DTC_MODE_SHORT: of1 = step1 && (st.t1_hi == `DTC_BYTE_TOP)
                && ((st.t1_lo & `DTC_LOW5_MASK) == `DTC_LOW5_TOP);
            DTC_MODE_FULL: of1 = step1 && (st.t1_hi == `DTC_BYTE_TOP)
                && (st.t1_lo == `DTC_BYTE_TOP);
            DTC_MODE_RELOAD: of1 = step1 && (st.t1_lo == `DTC_BYTE_TOP);
            DTC_MODE_SPLIT: of1 = 1'b0;
        endcase
    end

    always_comb begin
        unique case (avs_address)
            `DTC_OFF_CTRL: rd_byte = st.ctrl;
            `DTC_OFF_MODE: rd_byte = st.mode;
            `DTC_OFF_T0_LO: rd_byte = st.t0_lo;
            `DTC_OFF_T1_LO: rd_byte = st.t1_lo;
            `DTC_OFF_T0_HI: rd_byte = st.t0_hi;
            `DTC_OFF_T1_HI: rd_byte = st.t1_hi;
            default: rd_byte = `DTC_ZERO8;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st = st;
        // Two flops guard each interrupt pin; only the second stage and the
        // history behind it feed any gate or flag decision.
        next_st.ext_irq_zero_pin_s1 = ext_irq_zero_pin;
        next_st.ext_irq_zero_pin_s2 = st.ext_irq_zero_pin_s1;
        next_st.ext_irq_zero_pin_prev = st.ext_irq_zero_pin_s2;
        next_st.ext_irq_one_pin_s1 = ext_irq_one_pin;
        next_st.ext_irq_one_pin_s2 = st.ext_irq_one_pin_s1;
        next_st.ext_irq_one_pin_prev = st.ext_irq_one_pin_s2;
        // One wait state per access: the answer flop blocks a second take
        // while the master still holds its request.
        next_st.ack = (avs_read || avs_write) && !st.ack;
        // Read data is captured on the take and held until the next read, so
        // the master finds it stable at the edge where waitrequest is low.
        next_st.rdata = rd_hit ? {24'h000000, rd_byte} : st.rdata;

        // Control and mode writes land before the event logic so that a
        // same-cycle hardware flag set still wins over software.
        if (wr_hit && wr_lane) begin
            unique case (avs_address)
                `DTC_OFF_CTRL: next_st.ctrl = wbyte;
                `DTC_OFF_MODE: next_st.mode = wbyte;
                default: ;
            endcase
        end

        // Timer 0 low and high bytes.
        if (step0) begin
            unique case (mode0)
                DTC_MODE_SHORT: begin
                    if ((st.t0_lo & `DTC_LOW5_MASK) == `DTC_LOW5_TOP) begin
                        next_st.t0_lo = st.t0_lo & ~`DTC_LOW5_MASK;
                        next_st.t0_hi = st.t0_hi + `DTC_ONE8;
                    end else begin
                        next_st.t0_lo = st.t0_lo + `DTC_ONE8;
                    end
                end
                DTC_MODE_FULL: begin
                    next_st.t0_lo = st.t0_lo + `DTC_ONE8;
                    if (st.t0_lo == `DTC_BYTE_TOP) begin
                        next_st.t0_hi = st.t0_hi + `DTC_ONE8;
                    end
                end
                DTC_MODE_RELOAD: begin
                    next_st.t0_lo = of0 ? st.t0_hi : st.t0_lo + `DTC_ONE8;
                end
                DTC_MODE_SPLIT: begin
                    next_st.t0_lo = st.t0_lo + `DTC_ONE8;
                end
            endcase
        end
        if (en_split_hi) begin
            next_st.t0_hi = st.t0_hi + `DTC_ONE8;
        end

        // Timer 1 stands still while timer 0 is split.
        if (step1) begin
            unique case (mode1)
                DTC_MODE_SHORT: begin
                    if ((st.t1_lo & `DTC_LOW5_MASK) == `DTC_LOW5_TOP) begin
                        next_st.t1_lo = st.t1_lo & ~`DTC_LOW5_MASK;
                        next_st.t1_hi = st.t1_hi + `DTC_ONE8;
                    end else begin
                        next_st.t1_lo = st.t1_lo + `DTC_ONE8;
                    end
                end
                DTC_MODE_FULL: begin
                    next_st.t1_lo = st.t1_lo + `DTC_ONE8;
                    if (st.t1_lo == `DTC_BYTE_TOP) begin
                        next_st.t1_hi = st.t1_hi + `DTC_ONE8;
                    end
                end
                DTC_MODE_RELOAD: begin
                    next_st.t1_lo = of1 ? st.t1_hi : st.t1_lo + `DTC_ONE8;
                end
                DTC_MODE_SPLIT: ;
            endcase
        end

        // A byte write beats a same-cycle count step, so software can load a
        // running timer without the step overwriting the new value.
        if (wr_hit && wr_lane) begin
            unique case (avs_address)
                `DTC_OFF_T0_LO: next_st.t0_lo = wbyte;
                `DTC_OFF_T1_LO: next_st.t1_lo = wbyte;
                `DTC_OFF_T0_HI: next_st.t0_hi = wbyte;
                `DTC_OFF_T1_HI: next_st.t1_hi = wbyte;
                default: ;
            endcase
        end

        // Service completion clears; a same-cycle event sets again.
        if (timer_one_serviced) begin
            next_st.ctrl[`DTC_CTRL_TF1] = 1'b0;
        end
        if (timer_zero_serviced) begin
            next_st.ctrl[`DTC_CTRL_TF0] = 1'b0;
        end
        if (ext_irq_one_serviced) begin
            next_st.ctrl[`DTC_CTRL_IE1] = 1'b0;
        end
        if (ext_irq_zero_serviced) begin
            next_st.ctrl[`DTC_CTRL_IE0] = 1'b0;
        end
        if (of1 || of_split_hi) begin
            next_st.ctrl[`DTC_CTRL_TF1] = 1'b1;
        end
        if (of0) begin
            next_st.ctrl[`DTC_CTRL_TF0] = 1'b1;
        end
        // Level type re-arms every cycle the pin is low, so service cannot
        // clear a pending flag until the pin has gone high again.
        if (st.ctrl[`DTC_CTRL_IT1] ? (st.ext_irq_one_pin_prev && !st.ext_irq_one_pin_s2)
                                   : !st.ext_irq_one_pin_s2) begin
            next_st.ctrl[`DTC_CTRL_IE1] = 1'b1;
        end
        if (st.ctrl[`DTC_CTRL_IT0] ? (st.ext_irq_zero_pin_prev && !st.ext_irq_zero_pin_s2)
                                   : !st.ext_irq_zero_pin_s2) begin
            next_st.ctrl[`DTC_CTRL_IE0] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            // Pin stages preset high so no false edge follows reset.
            st <= '{ctrl: `DTC_BYTE_RESET, mode: `DTC_BYTE_RESET,
                    t0_lo: `DTC_BYTE_RESET, t0_hi: `DTC_BYTE_RESET,
                    t1_lo: `DTC_BYTE_RESET, t1_hi: `DTC_BYTE_RESET,
                    ext_irq_zero_pin_s1: 1'b1, ext_irq_zero_pin_s2: 1'b1, ext_irq_zero_pin_prev: 1'b1,
                    ext_irq_one_pin_s1: 1'b1, ext_irq_one_pin_s2: 1'b1, ext_irq_one_pin_prev: 1'b1,
                    ack: 1'b0, rdata: 32'h00000000};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Outputs come straight from state flip-flops.
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = !st.ack;
    assign timer_zero_irq = st.ctrl[`DTC_CTRL_TF0];
    assign timer_one_irq = st.ctrl[`DTC_CTRL_TF1];
    assign ext_irq_zero_irq = st.ctrl[`DTC_CTRL_IE0];
    assign ext_irq_one_irq = st.ctrl[`DTC_CTRL_IE1];

endmodule

// ===== verif/dtc_checker.sv
/* Port assertions for the dual timer/counter.
   Assumes a bind to dtc_top and a single sys_clk domain. */
`timescale 1ns/1ps
module dtc_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_zero_serviced,
    input wire logic timer_one_serviced,
    input wire logic ext_irq_zero_serviced,
    input wire logic ext_irq_one_serviced,
    input wire logic timer_zero_irq,
    input wire logic timer_one_irq,
    input wire logic ext_irq_zero_irq,
    input wire logic ext_irq_one_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst || !clk_en);
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    a_answer_once: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_read_upper: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest
        && (avs_address < 8'h88 || avs_address > 8'h8D)
        |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    // A flag drops only after service, a software write or a reset.
    a_t0_flag_hold: assert property ($fell(timer_zero_irq) |->
        $past(timer_zero_serviced) || $past(avs_write) || !$past(nrst))
        else $error("timer0 flag dropped on its own");
    a_t1_flag_hold: assert property ($fell(timer_one_irq) |->
        $past(timer_one_serviced) || $past(avs_write) || !$past(nrst))
        else $error("timer1 flag dropped on its own");
    a_e0_flag_hold: assert property ($fell(ext_irq_zero_irq) |->
        $past(ext_irq_zero_serviced) || $past(avs_write) || !$past(nrst))
        else $error("ext0 flag dropped on its own");
    a_e1_flag_hold: assert property ($fell(ext_irq_one_irq) |->
        $past(ext_irq_one_serviced) || $past(avs_write) || !$past(nrst))
        else $error("ext1 flag dropped on its own");
    c_t0_flag: cover property ($rose(timer_zero_irq));
    c_t1_flag: cover property ($rose(timer_one_irq));
    c_e0_flag: cover property ($rose(ext_irq_zero_irq));
endmodule
bind dtc_top dtc_checker u_chk (.*);

// ===== verif/dtc_pin_model.sv
/* Far-side model of the count and interrupt pins.
   Assumes the bench pulses fall_req for one cycle per wanted count. */
`timescale 1ns/1ps
module dtc_pin_model (
    input wire logic sys_clk,
    input wire logic [1:0] fall_req,
    input wire logic [1:0] gate_lvl,
    output logic count_input_zero,
    output logic count_input_one,
    output logic ext_irq_zero_pin,
    output logic ext_irq_one_pin
);
    logic [4:0] low_cnt [2] = '{5'h00, 5'h00};
    // Each pulse stays low 24 cycles so two 12-cycle samples see it.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (low_cnt[i] != 5'h00) begin
                low_cnt[i] <= low_cnt[i] - 5'h01;
            end else if (fall_req[i]) begin
                low_cnt[i] <= 5'h18;
            end
        end
    end
    assign count_input_zero = (low_cnt[0] == 5'h00);
    assign count_input_one = (low_cnt[1] == 5'h00);
    assign ext_irq_zero_pin = gate_lvl[0];
    assign ext_irq_one_pin = gate_lvl[1];
endmodule

// ===== verif/tb_dual_timer_counter.sv
/* Self-checking bench for the dual timer/counter.
   Assumes dtc_top, dtc_pin_model and the bound checker are compiled. */
`timescale 1ns/1ps
`include "dtc_consts.svh"
module tb_dual_timer_counter;
    logic sys_clk, nrst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address, d;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, serv, irq_v;
    logic [1:0] fall_req, gate_lvl;
    logic count_input_zero, count_input_one;
    logic ext_irq_zero_pin, ext_irq_one_pin;
    logic timer_zero_irq, timer_one_irq, ext_irq_zero_irq, ext_irq_one_irq;
    wire timer_zero_serviced = serv[0];
    wire timer_one_serviced = serv[1];
    wire ext_irq_zero_serviced = serv[2];
    wire ext_irq_one_serviced = serv[3];
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    assign irq_v = {ext_irq_one_irq, ext_irq_zero_irq, timer_one_irq,
        timer_zero_irq};
    dtc_top DUT (.*);
    dtc_pin_model u_pins (.*);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic rd, input logic [7:0] a,
        input logic [7:0] w, output logic [7:0] r);
        avs_address <= a;
        avs_writedata <= {24'h000000, w};
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        logic [7:0] r;
        bus(1'b0, a, w, r);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [7:0] e);
        logic [7:0] r;
        bus(1'b1, a, 8'h00, r);
        chk(nm, e, r);
    endtask
    task automatic wait_irq(input int i, input logic e, input string nm);
        for (int n = 0; n < 40 && irq_v[i] !== e; n++) @(posedge sys_clk);
        chk(nm, {7'h00, e}, {7'h00, irq_v[i]});
    endtask
    task automatic serve(input int i);
        serv[i] <= 1'b1;
        @(posedge sys_clk);
        serv[i] <= 1'b0;
        wait_irq(i, 1'b0, "serviced flag");
    endtask
    task automatic pin_fall(input int i, input int k);
        repeat (k) begin
            fall_req[i] <= 1'b1;
            @(posedge sys_clk);
            fall_req[i] <= 1'b0;
            repeat (40) @(posedge sys_clk);
        end
    endtask
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        serv = 4'h0;
        fall_req = 2'h0;
        gate_lvl = 2'h3;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 6; i++) rd_chk("reset", 8'h88 + i, 8'h00);
        for (int i = 2; i < 6; i++) begin
            wr(8'h88 + i, 8'hA5 ^ i);
            rd_chk("byte reg", 8'h88 + i, 8'hA5 ^ i);
        end
        avs_byteenable <= 4'hE;
        wr(`DTC_OFF_T0_LO, 8'h5A);
        avs_byteenable <= 4'hF;
        rd_chk("masked write", `DTC_OFF_T0_LO, 8'hA7);
        rd_chk("unmapped", 8'h80, 8'h00);
        $display("test registers done");
        wr(`DTC_OFF_T0_HI, 8'hFF);
        wr(`DTC_OFF_T0_LO, 8'hFE);
        wr(`DTC_OFF_MODE, 8'h01);
        wr(`DTC_OFF_CTRL, 8'h10);
        wait_irq(0, 1'b1, "mode1 overflow");
        serve(0);
        wr(`DTC_OFF_CTRL, 8'h00);
        rd_chk("mode1 wrap", `DTC_OFF_T0_HI, 8'h00);
        $display("test mode1 done");
        wr(`DTC_OFF_T1_HI, 8'hFF);
        wr(`DTC_OFF_T1_LO, 8'h1F);
        wr(`DTC_OFF_MODE, 8'h00);
        wr(`DTC_OFF_CTRL, 8'h40);
        wait_irq(1, 1'b1, "mode0 overflow");
        serve(1);
        wr(`DTC_OFF_CTRL, 8'h00);
        rd_chk("mode0 wrap", `DTC_OFF_T1_HI, 8'h00);
        $display("test mode0 done");
        wr(`DTC_OFF_T0_HI, 8'hF0);
        wr(`DTC_OFF_T0_LO, 8'hFE);
        wr(`DTC_OFF_MODE, 8'h02);
        wr(`DTC_OFF_CTRL, 8'h10);
        wait_irq(0, 1'b1, "mode2 overflow");
        clk_en <= 1'b0;
        serv[0] <= 1'b1;
        @(posedge sys_clk);
        serv[0] <= 1'b0;
        clk_en <= 1'b1;
        @(posedge sys_clk);
        chk("frozen service", 8'h01, {7'h00, timer_zero_irq});
        wr(`DTC_OFF_CTRL, 8'h00);
        rd_chk("reload source", `DTC_OFF_T0_HI, 8'hF0);
        bus(1'b1, `DTC_OFF_T0_LO, 8'h00, d);
        chk("reloaded low", 8'h01, {7'h00, d >= 8'hF0});
        $display("test mode2 done");
        wr(`DTC_OFF_T0_LO, 8'h00);
        wr(`DTC_OFF_MODE, 8'h0D);
        gate_lvl[0] <= 1'b0;
        wr(`DTC_OFF_CTRL, 8'h10);
        pin_fall(0, 1);
        rd_chk("gated count", `DTC_OFF_T0_LO, 8'h00);
        gate_lvl[0] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pin_fall(0, 3);
        rd_chk("pin count", `DTC_OFF_T0_LO, 8'h03);
        wr(`DTC_OFF_CTRL, 8'h00);
        pin_fall(0, 1);
        rd_chk("stopped count", `DTC_OFF_T0_LO, 8'h03);
        $display("test counter done");
        gate_lvl[1] <= 1'b0;
        wr(`DTC_OFF_T1_LO, 8'h00);
        wr(`DTC_OFF_MODE, 8'h90);
        wr(`DTC_OFF_CTRL, 8'h40);
        repeat (8) @(posedge sys_clk);
        rd_chk("gate1 shut", `DTC_OFF_T1_LO, 8'h00);
        gate_lvl[1] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wr(`DTC_OFF_CTRL, 8'h00);
        bus(1'b1, `DTC_OFF_T1_LO, 8'h00, d);
        chk("gate1 open", 8'h01, {7'h00, d != 8'h00});
        $display("test gate done");
        wr(`DTC_OFF_CTRL, 8'h01);
        gate_lvl[0] <= 1'b0;
        wait_irq(2, 1'b1, "ext0 edge");
        serve(2);
        gate_lvl[0] <= 1'b1;
        gate_lvl[1] <= 1'b0;
        wait_irq(3, 1'b1, "ext1 level");
        gate_lvl[1] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        serve(3);
        $display("test external done");
        wr(`DTC_OFF_T1_LO, 8'h55);
        wr(`DTC_OFF_T0_HI, 8'hFF);
        wr(`DTC_OFF_T0_LO, 8'h00);
        wr(`DTC_OFF_MODE, 8'h03);
        wr(`DTC_OFF_CTRL, 8'h40);
        wait_irq(1, 1'b1, "split high");
        wr(`DTC_OFF_CTRL, 8'h00);
        rd_chk("timer1 held", `DTC_OFF_T1_LO, 8'h55);
        rd_chk("split low", `DTC_OFF_T0_LO, 8'h00);
        $display("test split done");
        wrap_up();
    end
endmodule
